// ---- cfcr_pkg.sv ----
/*
  Package for the capture format control register bank: register offsets,
  field positions, reset values and format codes.
  Assumes a byte-addressed register port with 8-bit wide register data.
*/
package cfcr_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_FMT = 12'h0d4;
  localparam logic [11:0] OFS_COLOR = 12'h0d8;
  localparam logic [11:0] OFS_CAP = 12'h0dc;
  localparam logic [11:0] OFS_PKT_LO = 12'h0e0;
  localparam logic [11:0] OFS_PKT_DEL = 12'h0e4;
  localparam logic [11:0] OFS_FREQ_LO = 12'h0f0;
  localparam logic [11:0] OFS_FREQ_HI = 12'h0f4;
  localparam logic [11:0] OFS_DIVS = 12'h0f8;
  localparam logic [11:0] OFS_SW_RESET = 12'h07c;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Colour control bit positions
  localparam int BIT_EXT_RATE = 7;
  localparam int BIT_BARS = 6;
  localparam int BIT_DIFF_DIS = 5;
  localparam int BIT_GAMMA_DIS = 4;
  localparam int BIT_ODD_HALF = 3;
  localparam int BIT_EVEN_HALF = 2;
  localparam int BIT_ODD_OCTET = 1;
  localparam int BIT_EVEN_OCTET = 0;
  // Capture control bit positions
  localparam int BIT_DITHER_PIC = 4;
  localparam int BIT_ODD_VBI = 3;
  localparam int BIT_EVEN_VBI = 2;
  localparam int BIT_ODD_CAP = 1;
  localparam int BIT_EVEN_CAP = 0;
  localparam logic [7:0] CAP_WMASK = 8'h1f;
  // Packet delay register bit positions
  localparam int BIT_DELAY_LSB = 2;
  localparam int BIT_EXT_REGION = 1;
  localparam int BIT_LEN_MSB = 0;
  localparam logic [3:0] EXT_REGION_LINES = 4'ha;
  // Divider register bit positions
  localparam int BIT_PRE_DIV = 7;
  localparam int BIT_POST_DIV = 6;
  localparam logic [5:0] SYNTH_INT_MIN = 6'h06;
  localparam logic [2:0] POST_DIV_SIX = 3'h6;
  localparam logic [2:0] POST_DIV_FOUR = 3'h4;
  localparam logic [1:0] PRE_DIV_ONE = 2'h1;
  localparam logic [1:0] PRE_DIV_TWO = 2'h2;
  // Pixel format codes
  typedef enum logic [3:0] {
    FMT_RGB32 = 4'h0, FMT_RGB24 = 4'h1, FMT_RGB16 = 4'h2, FMT_RGB15 = 4'h3,
    FMT_PACK422 = 4'h4, FMT_PACK411 = 4'h5, FMT_Y8 = 4'h6, FMT_RGB8 = 4'h7,
    FMT_PLAN422 = 4'h8, FMT_PLAN411 = 4'h9, FMT_RAW8X = 4'he
  } cfcr_fmt_t;
endpackage : cfcr_pkg

// ---- cfcr_regs.sv ----
/*
  Capture format control register bank. Holds the per-field format,
  colour processing, capture enables, blanking packet and synthesiser
  settings, and decodes them into control levels for the pixel path.
  Assumes a single-cycle register port on CLK_SYS and a field flag and
  pixel-path data that arrive on the same clock.
*/
// Local design decision: strobed register access.
`timescale 1ns/1ps
module cfcr_regs (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [cfcr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [cfcr_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [cfcr_pkg::DATA_W-1:0] RDATA,
  input wire logic FIELD_EVEN,
  input wire logic GPIO_SERIAL16,
  input wire logic DECODER_PAL,
  input wire logic LINE_RESET_END,
  input wire logic PIXEL_RATE_CLOCK,
  input wire logic [31:0] PIXEL_WORD,
  output logic [31:0] FIFO_WORD,
  output logic [3:0] FIELD_FORMAT,
  output logic FORMAT_RESERVED,
  output logic GAMMA_TABLE_PAL,
  output logic GAMMA_REMOVE,
  output logic COLOUR_BARS,
  output logic DIFFUSE_ON,
  output logic DITHER_WHOLE_PICTURE,
  output logic ACTIVE_WRITE_EN,
  output logic BLANKING_WRITE_EN,
  output logic BLANKING_START,
  output logic [8:0] BLANKING_LENGTH,
  output logic EXTENDED_REGION_ENABLE,
  output logic [3:0] EXTRA_LINES,
  output logic [15:0] SYNTH_FREQ,
  output logic [5:0] SYNTH_INTEGER,
  output logic SYNTH_SLEEP,
  output logic SYNTH_INT_BAD,
  output logic [2:0] POST_DIVIDE,
  output logic [1:0] PRE_DIVIDE,
  output logic DECODER_RESET
);
  import cfcr_pkg::*;

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] color;
    logic [7:0] cap;
    logic [7:0] pkt_lo;
    logic [7:0] pkt_del;
    logic [7:0] freq_lo;
    logic [7:0] freq_hi;
    logic [7:0] divs;
    logic [7:0] rdata;
    logic [5:0] delay_cnt;
    logic delay_run;
    logic start;
    logic dec_rst;
    logic [31:0] word;
  } cfcr_state_t;

  cfcr_state_t s_q;
  cfcr_state_t s_d;
  logic [3:0] cur_fmt;
  logic half_x;
  logic octet_x;
  logic [31:0] w_tmp;

  // Per-field selection of format and swap controls
  always_comb begin
    cur_fmt = FIELD_EVEN ? s_q.fmt[3:0] : s_q.fmt[7:4];
    half_x = FIELD_EVEN ? s_q.color[BIT_EVEN_HALF]
                        : s_q.color[BIT_ODD_HALF];
    octet_x = FIELD_EVEN ? s_q.color[BIT_EVEN_OCTET]
                         : s_q.color[BIT_ODD_OCTET];
  end

  // Next state: register writes, reads, swap path and blanking delay
  always_comb begin
    s_d = s_q;
    s_d.rdata = REG_RESET;
    s_d.dec_rst = 1'b0;
    s_d.start = 1'b0;
    if (WR) begin
      unique case (ADDR)
        OFS_FMT: s_d.fmt = WDATA;
        OFS_COLOR: s_d.color = WDATA;
        OFS_CAP: s_d.cap = WDATA & CAP_WMASK;
        OFS_PKT_LO: s_d.pkt_lo = WDATA;
        OFS_PKT_DEL: s_d.pkt_del = WDATA;
        OFS_FREQ_LO: s_d.freq_lo = WDATA;
        OFS_FREQ_HI: s_d.freq_hi = WDATA;
        OFS_DIVS: s_d.divs = WDATA;
        OFS_SW_RESET: s_d.dec_rst = 1'b1;
        default: ;
      endcase
    end
    // Reads answer the next cycle; unmapped and reset location read zero
    if (RD) begin
      unique case (ADDR)
        OFS_FMT: s_d.rdata = s_q.fmt;
        OFS_COLOR: s_d.rdata = s_q.color;
        OFS_CAP: s_d.rdata = s_q.cap;
        OFS_PKT_LO: s_d.rdata = s_q.pkt_lo;
        OFS_PKT_DEL: s_d.rdata = s_q.pkt_del;
        OFS_FREQ_LO: s_d.rdata = s_q.freq_lo;
        OFS_FREQ_HI: s_d.rdata = s_q.freq_hi;
        OFS_DIVS: s_d.rdata = s_q.divs;
        default: s_d.rdata = REG_RESET;
      endcase
    end
    // Swap stages: half words first, then bytes within each half
    w_tmp = half_x ? {PIXEL_WORD[15:0], PIXEL_WORD[31:16]}
                   : PIXEL_WORD;
    s_d.word = octet_x ? {w_tmp[23:16], w_tmp[31:24],
                          w_tmp[7:0], w_tmp[15:8]} : w_tmp;
    // Blanking start delay counts pixel-rate enables after line reset
    if (LINE_RESET_END) begin
      s_d.delay_cnt = s_q.pkt_del[7:BIT_DELAY_LSB];
      s_d.delay_run = 1'b1;
      if (s_q.pkt_del[7:BIT_DELAY_LSB] == 6'h00) begin
        s_d.start = 1'b1;
        s_d.delay_run = 1'b0;
      end
    end else if (s_q.delay_run && PIXEL_RATE_CLOCK) begin
      s_d.delay_cnt = s_q.delay_cnt - 6'h01;
      if (s_q.delay_cnt == 6'h01) begin
        s_d.start = 1'b1;
        s_d.delay_run = 1'b0;
      end
    end
  end

  // One register for all state; synchronous reset to zero defaults
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Decoded control levels and the swapped FIFO word; the rest of the pixel path lives elsewhere
  always_comb begin
    RDATA = s_q.rdata;
    FIFO_WORD = s_q.word;
    FIELD_FORMAT = cur_fmt;
    // Raw 8X is legal only on the even field
    FORMAT_RESERVED = (cur_fmt > FMT_PLAN411) &&
                      !(FIELD_EVEN && cur_fmt == FMT_RAW8X);
    // Serial input mode takes the rate from software, else the decoder
    GAMMA_TABLE_PAL = GPIO_SERIAL16 ? s_q.color[BIT_EXT_RATE]
                                    : DECODER_PAL;
    GAMMA_REMOVE = !s_q.color[BIT_GAMMA_DIS];
    COLOUR_BARS = s_q.color[BIT_BARS];
    DIFFUSE_ON = !s_q.color[BIT_DIFF_DIS] &&
                 (cur_fmt == FMT_RGB16 || cur_fmt == FMT_RGB15);
    DITHER_WHOLE_PICTURE = s_q.cap[BIT_DITHER_PIC];
    ACTIVE_WRITE_EN = FIELD_EVEN ? s_q.cap[BIT_EVEN_CAP]
                                 : s_q.cap[BIT_ODD_CAP];
    BLANKING_WRITE_EN = FIELD_EVEN ? s_q.cap[BIT_EVEN_VBI]
                                   : s_q.cap[BIT_ODD_VBI];
    BLANKING_START = s_q.start;
    BLANKING_LENGTH = {s_q.pkt_del[BIT_LEN_MSB], s_q.pkt_lo};
    EXTENDED_REGION_ENABLE = s_q.pkt_del[BIT_EXT_REGION];
    EXTRA_LINES = s_q.pkt_del[BIT_EXT_REGION] ? EXT_REGION_LINES
                                              : 4'h0;
    SYNTH_FREQ = {s_q.freq_hi, s_q.freq_lo};
    SYNTH_INTEGER = s_q.divs[5:0];
    SYNTH_SLEEP = (s_q.divs[5:0] == 6'h00);
    SYNTH_INT_BAD = !SYNTH_SLEEP && (s_q.divs[5:0] < SYNTH_INT_MIN);
    POST_DIVIDE = s_q.divs[BIT_POST_DIV] ? POST_DIV_FOUR
                                         : POST_DIV_SIX;
    PRE_DIVIDE = s_q.divs[BIT_PRE_DIV] ? PRE_DIV_TWO
                                       : PRE_DIV_ONE;
    DECODER_RESET = s_q.dec_rst;
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_read_back: assert property (
    WR && ADDR == OFS_COLOR ##1 RD && ADDR == OFS_COLOR && !WR
    |=> RDATA == $past(WDATA, 2)) else $error("readback mismatch");
  a_sw_reset: assert property (
    WR && ADDR == OFS_SW_RESET |=> DECODER_RESET)
    else $error("software reset not pulsed");
  a_reset_pulse: assert property (
    DECODER_RESET |=> !DECODER_RESET || $past(WR))
    else $error("reset pulse stuck");
  a_cap_reserved: assert property (
    s_q.cap[7:5] == 3'h0) else $error("reserved capture bits set");
  a_half_swap: assert property (
    half_x && !octet_x |=> FIFO_WORD == {$past(PIXEL_WORD[15:0]),
    $past(PIXEL_WORD[31:16])}) else $error("half exchange wrong");
  a_octet_swap: assert property (
    !half_x && octet_x |=> FIFO_WORD[31:16] ==
    {$past(PIXEL_WORD[23:16]), $past(PIXEL_WORD[31:24])})
    else $error("byte exchange wrong");
  a_active_gate: assert property (
    ACTIVE_WRITE_EN |-> (FIELD_EVEN ? s_q.cap[0] : s_q.cap[1]))
    else $error("capture gate wrong");
  a_vbi_gate: assert property (
    BLANKING_WRITE_EN |-> (FIELD_EVEN ? s_q.cap[2] : s_q.cap[3]))
    else $error("blanking gate wrong");
  a_diffuse: assert property (
    DIFFUSE_ON |-> cur_fmt inside {4'h2, 4'h3}) else $error("diffusion");
  a_sleep: assert property (
    WR && ADDR == OFS_DIVS && WDATA[5:0] == 6'h00 |=> SYNTH_SLEEP)
    else $error("synth not asleep");
  a_zero_delay: assert property (
    LINE_RESET_END && s_q.pkt_del[7:2] == 6'h00 |=> BLANKING_START)
    else $error("blanking start late");
  a_start_pulse: assert property (
    BLANKING_START |=> !BLANKING_START)
    else $error("blanking start held");

  // Every write lands in its own register on the next edge
  a_fmt_write: assert property (
    WR && ADDR == OFS_FMT |=> s_q.fmt == $past(WDATA))
    else $error("format write lost");
  a_color_write: assert property (
    WR && ADDR == OFS_COLOR |=> s_q.color == $past(WDATA))
    else $error("colour write lost");
  a_cap_write: assert property (
    WR && ADDR == OFS_CAP |=> s_q.cap == ($past(WDATA) & CAP_WMASK))
    else $error("capture write lost");
  a_plo_write: assert property (
    WR && ADDR == OFS_PKT_LO |=> s_q.pkt_lo == $past(WDATA))
    else $error("length write lost");
  a_pdel_write: assert property (
    WR && ADDR == OFS_PKT_DEL |=> s_q.pkt_del == $past(WDATA))
    else $error("delay write lost");
  a_flo_write: assert property (
    WR && ADDR == OFS_FREQ_LO |=> s_q.freq_lo == $past(WDATA))
    else $error("freq low write lost");
  a_fhi_write: assert property (
    WR && ADDR == OFS_FREQ_HI |=> s_q.freq_hi == $past(WDATA))
    else $error("freq high write lost");
  a_div_write: assert property (
    WR && ADDR == OFS_DIVS |=> s_q.divs == $past(WDATA))
    else $error("divider write lost");

  // Registers only move when their own offset is written; a stray
  // decode would silently retune the pixel path
  a_fmt_hold: assert property (
    !(WR && ADDR == OFS_FMT) |=> $stable(s_q.fmt))
    else $error("format changed unasked");
  a_color_hold: assert property (
    !(WR && ADDR == OFS_COLOR) |=> $stable(s_q.color))
    else $error("colour changed unasked");
  a_cap_hold: assert property (
    !(WR && ADDR == OFS_CAP) |=> $stable(s_q.cap))
    else $error("capture changed unasked");
  a_plo_hold: assert property (
    !(WR && ADDR == OFS_PKT_LO) |=> $stable(s_q.pkt_lo))
    else $error("length changed unasked");
  a_pdel_hold: assert property (
    !(WR && ADDR == OFS_PKT_DEL) |=> $stable(s_q.pkt_del))
    else $error("delay changed unasked");
  a_flo_hold: assert property (
    !(WR && ADDR == OFS_FREQ_LO) |=> $stable(s_q.freq_lo))
    else $error("freq low changed unasked");
  a_fhi_hold: assert property (
    !(WR && ADDR == OFS_FREQ_HI) |=> $stable(s_q.freq_hi))
    else $error("freq high changed unasked");
  a_div_hold: assert property (
    !(WR && ADDR == OFS_DIVS) |=> $stable(s_q.divs))
    else $error("divider changed unasked");

  // Read data stand for one cycle only, then fall back to zero
  a_rdata_idle: assert property (
    !RD |=> RDATA == REG_RESET)
    else $error("read data not idle");
  a_read_fmt: assert property (
    RD && ADDR == OFS_FMT |=> RDATA == $past(s_q.fmt))
    else $error("format read wrong");
  a_read_div: assert property (
    RD && ADDR == OFS_DIVS |=> RDATA == $past(s_q.divs))
    else $error("divider read wrong");

  // Decoded controls follow the register fields, field flag and serial/decoder inputs at all times
  a_fmt_odd: assert property (
    !FIELD_EVEN |-> FIELD_FORMAT == s_q.fmt[7:4])
    else $error("odd format wrong");
  a_fmt_even: assert property (
    FIELD_EVEN |-> FIELD_FORMAT == s_q.fmt[3:0])
    else $error("even format wrong");
  a_raw_odd: assert property (
    !FIELD_EVEN && FIELD_FORMAT == FMT_RAW8X |-> FORMAT_RESERVED)
    else $error("raw accepted on odd field");
  a_raw_even: assert property (
    FIELD_EVEN && FIELD_FORMAT == FMT_RAW8X |-> !FORMAT_RESERVED)
    else $error("raw refused on even field");
  a_gamma_ext: assert property (
    GPIO_SERIAL16 |-> GAMMA_TABLE_PAL == s_q.color[BIT_EXT_RATE])
    else $error("gamma table not from rate bit");
  a_gamma_auto: assert property (
    !GPIO_SERIAL16 |-> GAMMA_TABLE_PAL == DECODER_PAL)
    else $error("gamma table not automatic");
  a_gamma_rm: assert property (
    GAMMA_REMOVE != s_q.color[BIT_GAMMA_DIS])
    else $error("gamma removal wrong");
  a_bars: assert property (
    COLOUR_BARS == s_q.color[BIT_BARS])
    else $error("colour bars wrong");
  a_no_diffuse: assert property (
    s_q.color[BIT_DIFF_DIS] |-> !DIFFUSE_ON)
    else $error("diffusion not disabled");
  a_dither: assert property (
    DITHER_WHOLE_PICTURE == s_q.cap[BIT_DITHER_PIC])
    else $error("dither mode wrong");
  a_length: assert property (
    BLANKING_LENGTH == {s_q.pkt_del[BIT_LEN_MSB], s_q.pkt_lo})
    else $error("packet length wrong");
  a_ext_lines: assert property (
    EXTRA_LINES == (EXTENDED_REGION_ENABLE ? EXT_REGION_LINES : 4'h0))
    else $error("extra lines wrong");
  a_freq: assert property (
    SYNTH_FREQ == {s_q.freq_hi, s_q.freq_lo})
    else $error("synth frequency wrong");
  a_int_bad: assert property (
    SYNTH_INT_BAD |-> SYNTH_INTEGER < SYNTH_INT_MIN && !SYNTH_SLEEP)
    else $error("divider range flag wrong");
  a_post_div: assert property (
    POST_DIVIDE == (s_q.divs[BIT_POST_DIV] ? POST_DIV_FOUR : POST_DIV_SIX))
    else $error("post divider wrong");
  a_pre_div: assert property (
    PRE_DIVIDE == (s_q.divs[BIT_PRE_DIV] ? PRE_DIV_TWO : PRE_DIV_ONE))
    else $error("pre divider wrong");
  a_no_swap: assert property (
    !half_x && !octet_x |=> FIFO_WORD == $past(PIXEL_WORD))
    else $error("word altered without swap");

  c_sw_reset: cover property (WR && ADDR == OFS_SW_RESET);
  c_delay: cover property (s_q.delay_run ##[1:300] BLANKING_START);
  c_both_swap: cover property (half_x && octet_x);
  c_raw: cover property (FIELD_EVEN && cur_fmt == FMT_RAW8X);
  c_back_read: cover property (WR && ADDR == OFS_COLOR ##1
    RD && ADDR == OFS_COLOR);
endmodule : cfcr_regs

// ---- cfcr_video_src.sv ----
/*
  Pixel-side source model for the capture format register bank: field
  flag, end of line reset, pixel-rate enables and a changing pixel word.
  Assumes the bench drives fld, go and slow just after a clock edge.
*/
`timescale 1ns/1ps
module cfcr_video_src (
  input wire logic clk,
  input wire logic rst,
  input wire logic fld,
  input wire logic go,
  input wire logic slow,
  output logic field_even,
  output logic line_end,
  output logic pix_en,
  output logic [31:0] pix_word
);
  logic [3:0] left_q;
  logic ph_q;
  // A line is a line-end pulse, then twelve pixel enables
  // The word moves every cycle, so a stuck swap path cannot pass
  always_ff @(posedge clk) begin
    field_even <= fld;
    line_end <= go & !rst;
    pix_word <= rst ? 32'h1234_5678 : pix_word * 32'h0001_0193 + 32'h9e37;
    ph_q <= !ph_q & !rst;
    pix_en <= 1'b0;
    if (rst || go) begin
      left_q <= rst ? 4'h0 : 4'hc;
    end else if (left_q != 4'h0 && (!slow || ph_q)) begin
      pix_en <= 1'b1; // Slow mode gives one enable every other cycle
      left_q <= left_q - 4'h1;
    end
  end
endmodule : cfcr_video_src

// ---- tb_capture_format_control_regs.sv ----
/*
  Self-checking bench for the capture format register bank.
  Assumes the register package and the pixel-side source model.
*/
`timescale 1ns/1ps
module tb_capture_format_control_regs;
  import cfcr_pkg::*;
  logic CLK_SYS = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic GPIO_SERIAL16 = 1'b0, DECODER_PAL = 1'b0;
  logic fld = 1'b0, go = 1'b0, slow = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [7:0] WDATA = 8'h00, RDATA, col_sh, del_sh;
  logic FIELD_EVEN, LINE_RESET_END, PIXEL_RATE_CLOCK, FORMAT_RESERVED;
  logic GAMMA_TABLE_PAL, GAMMA_REMOVE, COLOUR_BARS, DIFFUSE_ON, SYNTH_SLEEP;
  logic DITHER_WHOLE_PICTURE, ACTIVE_WRITE_EN, BLANKING_WRITE_EN;
  logic BLANKING_START, EXTENDED_REGION_ENABLE, SYNTH_INT_BAD, DECODER_RESET;
  logic [31:0] PIXEL_WORD, FIFO_WORD, fifo_exp;
  logic [3:0] FIELD_FORMAT, EXTRA_LINES, code;
  logic [8:0] BLANKING_LENGTH;
  logic [15:0] SYNTH_FREQ;
  logic [5:0] SYNTH_INTEGER;
  logic [2:0] POST_DIVIDE;
  logic [1:0] PRE_DIVIDE;
  logic blank_exp = 1'b0, armed = 1'b0, mon_ok = 1'b0;
  int err_total = 0, samples_checked = 0, pcnt = 0;
  logic [11:0] ofs [8] = '{OFS_FMT, OFS_COLOR, OFS_CAP, OFS_PKT_LO,
    OFS_PKT_DEL, OFS_FREQ_LO, OFS_FREQ_HI, OFS_DIVS};
  logic [7:0] dv [4] = '{8'h00, 8'h45, 8'h86, 8'hff};
  logic [7:0] cv [2] = '{8'h1a, 8'h05};

  cfcr_regs i_dut (.CLK_SYS, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .FIELD_EVEN, .GPIO_SERIAL16, .DECODER_PAL, .LINE_RESET_END,
    .PIXEL_RATE_CLOCK, .PIXEL_WORD, .FIFO_WORD, .FIELD_FORMAT,
    .FORMAT_RESERVED, .GAMMA_TABLE_PAL, .GAMMA_REMOVE, .COLOUR_BARS,
    .DIFFUSE_ON, .DITHER_WHOLE_PICTURE, .ACTIVE_WRITE_EN,
    .BLANKING_WRITE_EN, .BLANKING_START, .BLANKING_LENGTH,
    .EXTENDED_REGION_ENABLE, .EXTRA_LINES, .SYNTH_FREQ, .SYNTH_INTEGER,
    .SYNTH_SLEEP, .SYNTH_INT_BAD, .POST_DIVIDE, .PRE_DIVIDE, .DECODER_RESET);
  cfcr_video_src i_src (.clk(CLK_SYS), .rst(RST), .fld, .go, .slow,
    .field_even(FIELD_EVEN), .line_end(LINE_RESET_END),
    .pix_en(PIXEL_RATE_CLOCK), .pix_word(PIXEL_WORD));

  // 50 MHz system clock
  always #10 CLK_SYS = ~CLK_SYS;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // One-cycle write; the idle cycle after it avoids re-driving WR at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    @(posedge CLK_SYS);
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    chk(RDATA, e);
    @(posedge CLK_SYS);
    #1;
  endtask : rdc

  // The field flag passes a flop in the source model, so allow two edges
  task automatic setf(input int fe);
    fld <= 1'(fe);
    repeat (2) @(posedge CLK_SYS);
    #1;
  endtask : setf

  task automatic line(input logic s);
    slow <= s;
    go <= 1'b1;
    @(posedge CLK_SYS);
    go <= 1'b0;
    repeat (30) @(posedge CLK_SYS);
    #1;
  endtask : line

  // Per-cycle reference for the FIFO word and the blanking start pulse;
  // it shadows colour and packet delay writes so any test order is covered
  always @(posedge CLK_SYS) begin
    if (RST) begin
      col_sh = 8'h00;
      del_sh = 8'h00;
      armed = 1'b0;
      mon_ok = 1'b0;
    end else begin
      if (mon_ok) begin
        chk(FIFO_WORD, fifo_exp);
        chk(BLANKING_START, blank_exp);
      end
      fifo_exp = PIXEL_WORD;
      if (FIELD_EVEN ? col_sh[2] : col_sh[3])
        fifo_exp = {fifo_exp[15:0], fifo_exp[31:16]};
      if (FIELD_EVEN ? col_sh[0] : col_sh[1])
        fifo_exp = {fifo_exp[23:16], fifo_exp[31:24], fifo_exp[7:0],
          fifo_exp[15:8]};
      blank_exp = 1'b0;
      if (LINE_RESET_END) begin
        armed = 1'b1;
        pcnt = 0;
      end else if (armed && PIXEL_RATE_CLOCK)
        pcnt++;
      if (armed && pcnt == int'(del_sh[7:2])) begin
        blank_exp = 1'b1;
        armed = 1'b0;
      end
      if (WR && ADDR == OFS_COLOR) col_sh = WDATA;
      if (WR && ADDR == OFS_PKT_DEL) del_sh = WDATA;
      mon_ok = 1'b1;
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    #1;
    foreach (ofs[i]) rdc(ofs[i], 8'h00);
    chk(POST_DIVIDE, POST_DIV_SIX);
    chk(PRE_DIVIDE, PRE_DIV_ONE);
    chk(SYNTH_SLEEP, 1'b1);
    chk(GAMMA_REMOVE, 1'b1);
    $display("Reset test done");
    foreach (ofs[i]) wr(ofs[i], i == 2 ? 8'h07 : 8'ha5 + 8'(i));
    foreach (ofs[i]) rdc(ofs[i], i == 2 ? 8'h07 : 8'ha5 + 8'(i));
    wr(12'h0e8, 8'hff);
    rdc(12'h0e8, 8'h00);
    chk(SYNTH_FREQ, 16'habaa);
    ADDR <= OFS_SW_RESET;
    WDATA <= 8'h3c;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    #1;
    chk(DECODER_RESET, 1'b1);
    @(posedge CLK_SYS);
    #1;
    chk(DECODER_RESET, 1'b0);
    // Write then read the same register back to back, no gap
    ADDR <= OFS_COLOR;
    WDATA <= 8'h5a;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    chk(RDATA, 8'h5a);
    rdc(OFS_FREQ_HI, 8'hab);
    $display("Register test done");
    foreach (dv[i]) begin
      wr(OFS_DIVS, dv[i]);
      chk(SYNTH_INTEGER, dv[i][5:0]);
      chk(SYNTH_SLEEP, dv[i][5:0] == 6'h00);
      chk(SYNTH_INT_BAD, dv[i][5:0] inside {[1:5]});
      chk(POST_DIVIDE, dv[i][6] ? POST_DIV_FOUR : POST_DIV_SIX);
      chk(PRE_DIVIDE, dv[i][7] ? PRE_DIV_TWO : PRE_DIV_ONE);
    end
    wr(OFS_COLOR, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(OFS_FMT, {4'(c), 4'(15 - c)});
      for (int fe = 0; fe < 2; fe++) begin
        setf(fe);
        code = fe ? 4'(15 - c) : 4'(c);
        chk(FIELD_FORMAT, code);
        chk(FORMAT_RESERVED, code > 4'h9 && !(fe && code == 4'he));
        chk(DIFFUSE_ON, code inside {4'h2, 4'h3});
      end
    end
    $display("Format test done");
    wr(OFS_FMT, 8'h22);
    wr(OFS_COLOR, 8'hf0);
    GPIO_SERIAL16 <= 1'b1;
    setf(0);
    chk(GAMMA_TABLE_PAL, 1'b1);
    chk(COLOUR_BARS, 1'b1);
    chk(GAMMA_REMOVE, 1'b0);
    chk(DIFFUSE_ON, 1'b0);
    wr(OFS_COLOR, 8'h00);
    DECODER_PAL <= 1'b1;
    setf(0);
    chk(GAMMA_TABLE_PAL, 1'b0);
    chk(COLOUR_BARS, 1'b0);
    GPIO_SERIAL16 <= 1'b0;
    setf(0);
    chk(GAMMA_TABLE_PAL, 1'b1);
    $display("Colour test done");
    wr(OFS_PKT_LO, 8'h34);
    wr(OFS_PKT_DEL, 8'h0f);
    chk(BLANKING_LENGTH, 9'h134);
    chk(EXTENDED_REGION_ENABLE, 1'b1);
    chk(EXTRA_LINES, EXT_REGION_LINES);
    wr(OFS_COLOR, 8'h0a);
    line(1'b1);
    wr(OFS_COLOR, 8'h05);
    fld <= 1'b1;
    line(1'b0);
    wr(OFS_PKT_DEL, 8'h00);
    line(1'b0);
    chk(EXTRA_LINES, 4'h0);
    // One swap alone per field: even gets bytes only, odd halves only
    wr(OFS_COLOR, 8'h09);
    line(1'b0);
    fld <= 1'b0;
    line(1'b0);
    $display("Line test done");
    foreach (cv[i]) begin
      wr(OFS_CAP, cv[i]);
      for (int fe = 0; fe < 2; fe++) begin
        setf(fe);
        chk(ACTIVE_WRITE_EN, fe ? cv[i][0] : cv[i][1]);
        chk(BLANKING_WRITE_EN, fe ? cv[i][2] : cv[i][3]);
        chk(DITHER_WHOLE_PICTURE, cv[i][4]);
      end
    end
    $display("Capture test done");
    end_sim();
  end

  // Watchdog: the tests take a few hundred cycles
  initial begin
    #(20 * 20000);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : tb_capture_format_control_regs
